// ==== tuner_pll_serial_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_serial_control #(
  parameter int TB_PERIOD_CYC = tuner_pll_pkg::TB_PERIOD_CYC,
  parameter int TB_HIGH_CYC   = tuner_pll_pkg::TB_HIGH_CYC,
  parameter int GATE_CYC      = tuner_pll_pkg::GATE_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Four-wire serial link
  input  wire logic        bus_select,
  input  wire logic        bus_shift_strobe,
  input  wire logic        serial_in_line,
  output logic             serial_out_o,
  output logic             serial_out_oe_n,
  // Bidirectional ports
  input  wire logic        bidir_pin_one_i,
  output logic             bidir_pin_one_o,
  output logic             bidir_pin_one_oe_n,
  input  wire logic        bidir_pin_two_i,
  output logic             bidir_pin_two_o,
  output logic             bidir_pin_two_oe_n,
  // PLL core side
  input  wire logic        pll_unlocked_in,
  input  wire logic        phase_pump_drive,
  input  wire logic        count_signal_input,
  output logic             timebase_out_pin,
  output logic             charge_pump_out,
  output logic             charge_pump_force_low,
  output logic             input_sensitivity_sel,
  output logic [2:0]       factory_test_bits,
  output logic             fm_local_osc_input,
  output logic             am_local_osc_input,
  output logic [16:0]      effective_divisor,
  output logic [3:0]       ref_select,
  output logic             ref_is_25khz
);
  localparam int NS = 8;

  logic [NS-1:0]                        sync1_r;
  logic [NS-1:0]                        sync2_r;
  logic [NS-1:0]                        prev_r;
  tuner_pll_pkg::link_state_t           state_r;
  logic [5:0]                           bitcnt_r;
  logic [7:0]                           addr_r;
  logic [7:0]                           addr_nxt;
  logic [tuner_pll_pkg::CTRL_W-1:0]     shin_r;
  logic [tuner_pll_pkg::CTRL_W-1:0]     ctrl_r;
  logic [tuner_pll_pkg::OUT_W-1:0]      shout_r;
  logic [1:0]                           io_lat_r;
  logic [tuner_pll_pkg::EV_W-1:0]       status_r;
  logic [tuner_pll_pkg::EV_W-1:0]       mask_r;
  logic [31:0]                          prdata_r;
  logic                                 lock_d_r;
  logic                                 sel_s;
  logic                                 sel_rise;
  logic                                 sel_fall;
  logic                                 stb_rise;
  logic                                 din_s;
  logic                                 lock_flag;
  logic                                 word_ok;
  logic                                 tb_wave;
  logic [tuner_pll_pkg::EV_W-1:0]       ev;
  logic [tuner_pll_pkg::EV_W-1:0]       rd_clr;
  logic                                 access;
  logic [15:0]                          div;
  logic [1:0]                           ul_sel;

  count_if cnt_if ();

  // Every serial link, bidirectional port and PLL core pin passes two flops before use
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= {count_signal_input, phase_pump_drive, pll_unlocked_in,
                  bidir_pin_two_i, bidir_pin_one_i, serial_in_line,
                  bus_shift_strobe, bus_select};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign sel_s    = sync2_r[0];
  assign din_s    = sync2_r[2];
  assign sel_rise = sync2_r[0] & ~prev_r[0];
  assign sel_fall = ~sync2_r[0] & prev_r[0];
  // Only rising strobe edges count, so the idle level does not matter
  assign stb_rise = sync2_r[1] & ~prev_r[1];
  assign addr_nxt = {din_s, addr_r[7:1]};
  assign div      = ctrl_r[tuner_pll_pkg::F_DIV_HI:tuner_pll_pkg::F_DIV_LO];
  assign ul_sel   = ctrl_r[tuner_pll_pkg::F_UL_HI:tuner_pll_pkg::F_UL_LO];
  assign word_ok  = (state_r == tuner_pll_pkg::ST_IN) &&
                    (bitcnt_r == 6'(tuner_pll_pkg::CTRL_W));
  // Detection disabled reports locked
  assign lock_flag = (ul_sel == 2'b00) ? 1'b1 : ~sync2_r[5];

  // Frame engine: address byte, then control word or readback
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r  <= tuner_pll_pkg::ST_IDLE;
      bitcnt_r <= 6'h00;
      addr_r   <= 8'h00;
      shin_r   <= '0;
      shout_r  <= '0;
      io_lat_r <= 2'b00;
    end else if (sel_rise) begin
      state_r  <= tuner_pll_pkg::ST_ADDR;
      bitcnt_r <= 6'h00;
    end else if (!sel_s) begin
      state_r <= tuner_pll_pkg::ST_IDLE;
    end else if (stb_rise) begin
      case (state_r)
        tuner_pll_pkg::ST_ADDR: begin
          addr_r   <= addr_nxt;
          bitcnt_r <= bitcnt_r + 6'h01;
          if (bitcnt_r == 6'(tuner_pll_pkg::ADDR_W - 1)) begin
            bitcnt_r <= 6'h00;
            if (addr_nxt == tuner_pll_pkg::ADDR_IN) begin
              state_r <= tuner_pll_pkg::ST_IN;
            end else if (addr_nxt == tuner_pll_pkg::ADDR_OUT) begin
              state_r  <= tuner_pll_pkg::ST_OUT;
              io_lat_r <= {sync2_r[4], sync2_r[3]};
              shout_r  <= {sync2_r[4], sync2_r[3], lock_flag,
                           cnt_if.value};
            end else begin
              state_r <= tuner_pll_pkg::ST_IDLE;
            end
          end
        end
        tuner_pll_pkg::ST_IN: begin
          // First bit ends in bit 0; extra bits beyond the word are dropped
          if (bitcnt_r != 6'(tuner_pll_pkg::CTRL_W)) begin
            shin_r   <= {din_s, shin_r[tuner_pll_pkg::CTRL_W-1:1]};
            bitcnt_r <= bitcnt_r + 6'h01;
          end
        end
        tuner_pll_pkg::ST_OUT: begin
          shout_r <= {shout_r[tuner_pll_pkg::OUT_W-2:0], 1'b0};
        end
        default: begin
          state_r <= tuner_pll_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Short words are discarded rather than half applied
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_r <= tuner_pll_pkg::CTRL_RST;
    end else if (sel_fall && word_ok) begin
      ctrl_r <= shin_r;
    end
  end

  // Divider path, reference and pin outputs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fm_local_osc_input <= 1'b0;
      am_local_osc_input <= 1'b0;
      effective_divisor  <= 17'h0_0000;
      ref_select         <= 4'h0;
      ref_is_25khz       <= 1'b0;
    end else begin
      ref_select   <= ctrl_r[tuner_pll_pkg::F_REF_HI:tuner_pll_pkg::F_REF_LO];
      ref_is_25khz <= (ctrl_r[tuner_pll_pkg::F_REF_HI:tuner_pll_pkg::F_REF_LO]
                       == tuner_pll_pkg::REF_25K);
      if (ctrl_r[tuner_pll_pkg::F_PRESCALE]) begin
        fm_local_osc_input <= 1'b1;
        am_local_osc_input <= 1'b0;
        effective_divisor  <= {div, 1'b0};
      end else if (ctrl_r[tuner_pll_pkg::F_AM_SPEED]) begin
        fm_local_osc_input <= 1'b0;
        am_local_osc_input <= 1'b1;
        effective_divisor  <= {1'b0, div};
      end else begin
        fm_local_osc_input <= 1'b0;
        am_local_osc_input <= 1'b1;
        effective_divisor  <= {5'h00, div[15:4]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      timebase_out_pin      <= 1'b0;
      charge_pump_out       <= 1'b0;
      charge_pump_force_low <= 1'b0;
      input_sensitivity_sel <= 1'b0;
      factory_test_bits     <= 3'h0;
      bidir_pin_one_o       <= 1'b0;
      bidir_pin_one_oe_n    <= 1'b1;
      bidir_pin_two_o       <= 1'b0;
      bidir_pin_two_oe_n    <= 1'b1;
      serial_out_oe_n       <= 1'b1;
    end else begin
      timebase_out_pin <= ctrl_r[tuner_pll_pkg::F_TB_EN] ? tb_wave :
                          ctrl_r[tuner_pll_pkg::F_TB_DATA];
      charge_pump_force_low <= ctrl_r[tuner_pll_pkg::F_CP_FORCE];
      charge_pump_out <= ctrl_r[tuner_pll_pkg::F_CP_FORCE] ? 1'b0 :
                         sync2_r[6];
      input_sensitivity_sel <= ctrl_r[tuner_pll_pkg::F_SENS];
      factory_test_bits <=
        ctrl_r[tuner_pll_pkg::F_TEST_HI:tuner_pll_pkg::F_TEST_LO];
      bidir_pin_one_o    <= ctrl_r[tuner_pll_pkg::F_IO1_DATA];
      bidir_pin_one_oe_n <= ~ctrl_r[tuner_pll_pkg::F_IO1_DIR];
      bidir_pin_two_o    <= ctrl_r[tuner_pll_pkg::F_IO2_DATA];
      bidir_pin_two_oe_n <= ~ctrl_r[tuner_pll_pkg::F_IO2_DIR];
      if (state_r == tuner_pll_pkg::ST_OUT) begin
        serial_out_oe_n <= shout_r[tuner_pll_pkg::OUT_W-1];
      end else begin
        serial_out_oe_n <= ~(ctrl_r[tuner_pll_pkg::F_UNL_OUT] &
                             ~lock_flag);
      end
    end
  end

  // Open drain: the pin only ever pulls low
  assign serial_out_o = 1'b0;

  assign cnt_if.enable = ctrl_r[tuner_pll_pkg::F_CNT_EN];
  assign cnt_if.pulse  = sync2_r[7] & ~prev_r[7];

  freq_counter #(.GATE_CYC(GATE_CYC)) u_counter (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .cnt     (cnt_if.counter)
  );

  timebase_gen #(.PERIOD_CYC(TB_PERIOD_CYC), .HIGH_CYC(TB_HIGH_CYC)) u_tb (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wave    (tb_wave)
  );

  // Sticky events; only bits returned by the read are cleared
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == tuner_pll_pkg::OFF_CTRL_LO) ||
             (a == tuner_pll_pkg::OFF_CTRL_HI) ||
             (a == tuner_pll_pkg::OFF_STATUS) ||
             (a == tuner_pll_pkg::OFF_MASK) ||
             (a == tuner_pll_pkg::OFF_COUNT);
  endfunction

  assign access = psel && penable;
  assign ev     = {lock_d_r & ~lock_flag, cnt_if.done, sel_fall & word_ok};
  assign rd_clr = (access && !pwrite && paddr == tuner_pll_pkg::OFF_STATUS) ?
                  prdata_r[tuner_pll_pkg::EV_W-1:0] : '0;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_r <= '0;
      lock_d_r <= 1'b1;
    end else begin
      status_r <= (status_r & ~rd_clr) | ev;
      lock_d_r <= lock_flag;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mask_r <= '0;
    end else if (access && pwrite && paddr == tuner_pll_pkg::OFF_MASK) begin
      mask_r <= pwdata[tuner_pll_pkg::EV_W-1:0];
    end
  end

  // Read data captured in the setup phase, zero wait states
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == tuner_pll_pkg::OFF_CTRL_LO) begin
        prdata_r <= ctrl_r[31:0];
      end else if (paddr == tuner_pll_pkg::OFF_CTRL_HI) begin
        prdata_r <= {25'h000_0000, ctrl_r[tuner_pll_pkg::CTRL_W-1:32]};
      end else if (paddr == tuner_pll_pkg::OFF_STATUS) begin
        prdata_r <= {29'h0000_0000, status_r};
      end else if (paddr == tuner_pll_pkg::OFF_MASK) begin
        prdata_r <= {29'h0000_0000, mask_r};
      end else if (paddr == tuner_pll_pkg::OFF_COUNT) begin
        prdata_r <= {9'h000, io_lat_r, lock_flag, cnt_if.value};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped(paddr);
  assign irq     = |(status_r & mask_r);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_word_ready;
    word_ok;
  endsequence
  sequence s_select_drop;
    sel_fall;
  endsequence

  a_word_latch: assert property (
    (s_word_ready and s_select_drop) |=> (ctrl_r == $past(shin_r)))
    else $error("control word not latched on select fall");
  a_tb_override: assert property (
    ctrl_r[tuner_pll_pkg::F_TB_EN] |=> (timebase_out_pin == $past(tb_wave)))
    else $error("time base pin not following the wave");
  a_pump_force: assert property (
    ctrl_r[tuner_pll_pkg::F_CP_FORCE] |=> !charge_pump_out)
    else $error("pump output not forced low");
  a_test_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
    !reset_n |=> (ctrl_r[tuner_pll_pkg::F_TEST_HI:tuner_pll_pkg::F_TEST_LO]
                  == 3'h0))
    else $error("test bits not cleared by reset");
  a_io_sample: assert property (
    (stb_rise && state_r == tuner_pll_pkg::ST_ADDR &&
     bitcnt_r == 6'(tuner_pll_pkg::ADDR_W - 1) &&
     addr_nxt == tuner_pll_pkg::ADDR_OUT)
    |=> (io_lat_r == $past(sync2_r[4:3])) &&
        (shout_r[tuner_pll_pkg::OUT_W-1 -: 2] == $past(sync2_r[4:3])) &&
        (shout_r[19:0] == $past(cnt_if.value)))
    else $error("readback not loaded from pin levels and count");
  // Pin level two edges back, the depth of the synchroniser
  a_lock_flag: assert property (
    lock_flag == ((ul_sel == 2'b00) || !$past(pll_unlocked_in, 2)))
    else $error("lock flag wrong");
  a_fm_double: assert property (
    ctrl_r[tuner_pll_pkg::F_PRESCALE] |=>
      fm_local_osc_input && (effective_divisor == {$past(div), 1'b0}))
    else $error("FM path divisor not doubled");
  a_am_fast: assert property (
    (!ctrl_r[tuner_pll_pkg::F_PRESCALE] && ctrl_r[tuner_pll_pkg::F_AM_SPEED])
    |=> am_local_osc_input && (effective_divisor == {1'b0, $past(div)}))
    else $error("fast AM path wrong");
  a_am_direct: assert property (
    (!ctrl_r[tuner_pll_pkg::F_PRESCALE] && !ctrl_r[tuner_pll_pkg::F_AM_SPEED])
    |=> (effective_divisor == {5'h00, $past(div[15:4])}))
    else $error("direct division divisor wrong");
  a_ref_25k: assert property (
    (ctrl_r[tuner_pll_pkg::F_REF_HI:tuner_pll_pkg::F_REF_LO] ==
     tuner_pll_pkg::REF_25K)
    |=> ref_is_25khz)
    else $error("25 kHz reference not selected");
  a_unlock_pin: assert property (
    (state_r != tuner_pll_pkg::ST_OUT && ctrl_r[tuner_pll_pkg::F_UNL_OUT] &&
     !lock_flag) |=> !serial_out_oe_n)
    else $error("unlock not pulled onto serial output");
endmodule
`default_nettype wire

// ==== tuner_pll_pkg.sv ====
package tuner_pll_pkg;
  // Clock and slow-rate timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int TB_FREQ_HZ  = 8;
  localparam int TB_DUTY_PCT = 40;
  localparam int TB_PERIOD_CYC = CLK_HZ / TB_FREQ_HZ;
  localparam int TB_HIGH_CYC   = TB_PERIOD_CYC * TB_DUTY_PCT / 100;
  localparam int GATE_TIME_MS  = 4;
  localparam int GATE_CYC      = CLK_HZ / 1000 * GATE_TIME_MS;

  // Serial link framing
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] ADDR_IN  = 8'hA5;
  localparam logic [7:0] ADDR_OUT = 8'h5A;
  localparam int         CTRL_W   = 39;
  localparam int         CNT_W    = 20;
  localparam int         OUT_W    = 23;

  // Control word field positions, first shifted bit is bit 0
  localparam int F_DIV_LO   = 0;
  localparam int F_DIV_HI   = 15;
  localparam int F_AM_SPEED = 16;
  localparam int F_PRESCALE = 17;
  localparam int F_CNT_EN   = 18;
  localparam int F_XTAL     = 19;
  localparam int F_REF_LO   = 20;
  localparam int F_REF_HI   = 23;
  localparam int F_TB_EN    = 24;
  localparam int F_CP_FORCE = 25;
  localparam int F_SENS     = 26;
  localparam int F_TEST_LO  = 27;
  localparam int F_TEST_HI  = 29;
  localparam int F_RSV      = 30;
  localparam int F_UL_LO    = 31;
  localparam int F_UL_HI    = 32;
  localparam int F_TB_DATA  = 33;
  localparam int F_IO1_DIR  = 34;
  localparam int F_IO2_DIR  = 35;
  localparam int F_IO1_DATA = 36;
  localparam int F_IO2_DATA = 37;
  localparam int F_UNL_OUT  = 38;
  localparam logic [CTRL_W-1:0] CTRL_RST = 39'h00_0000_0000;
  localparam logic [3:0]        REF_25K  = 4'h2;

  // APB register map
  localparam logic [7:0] OFF_CTRL_LO = 8'h00;
  localparam logic [7:0] OFF_CTRL_HI = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_MASK    = 8'h0C;
  localparam logic [7:0] OFF_COUNT   = 8'h10;
  localparam int EV_W      = 3;
  localparam int EV_LATCH  = 0;
  localparam int EV_DONE   = 1;
  localparam int EV_UNLOCK = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_IN   = 4'h4,
    ST_OUT  = 4'h8
  } link_state_t;
endpackage

// ==== count_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface count_if;
  logic                          enable;
  logic                          pulse;
  logic                          done;
  logic [tuner_pll_pkg::CNT_W-1:0] value;
  modport counter (input enable, input pulse, output done, output value);
  modport owner   (output enable, output pulse, input done, input value);
endinterface
`default_nettype wire

// ==== freq_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module freq_counter #(
  parameter int GATE_CYC = tuner_pll_pkg::GATE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Count channel
  count_if.counter cnt
);
  logic                            en_d_r;
  logic                            gate_r;
  logic [31:0]                     gate_cnt_r;
  logic [tuner_pll_pkg::CNT_W-1:0] value_r;
  logic                            done_r;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= cnt.enable;
    end
  end

  // Held cleared while disabled, gate opens on the rising enable
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !cnt.enable) begin
      gate_r     <= 1'b0;
      gate_cnt_r <= 32'h0000_0000;
      value_r    <= '0;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!en_d_r) begin
        gate_r     <= 1'b1;
        gate_cnt_r <= 32'h0000_0000;
      end else if (gate_r) begin
        if (cnt.pulse) begin
          value_r <= value_r + 1'b1;
        end
        if (gate_cnt_r == 32'(GATE_CYC - 1)) begin
          gate_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          gate_cnt_r <= gate_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  assign cnt.done  = done_r;
  assign cnt.value = value_r;

  a_cnt_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !cnt.enable |=> (value_r == '0) && !done_r && !gate_r)
    else $error("counter not held while disabled");
  a_cnt_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cnt.enable && !en_d_r) |=> gate_r && (value_r == '0))
    else $error("measurement did not start");
endmodule
`default_nettype wire

// ==== timebase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module timebase_gen #(
  parameter int PERIOD_CYC = tuner_pll_pkg::TB_PERIOD_CYC,
  parameter int HIGH_CYC   = tuner_pll_pkg::TB_HIGH_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Square wave
  output logic      wave
);
  logic [31:0] cnt_r;
  logic        wave_r;

  // Free running so the wave phase does not jump on enable
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r == 32'(PERIOD_CYC - 1)) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wave_r <= 1'b0;
    end else begin
      wave_r <= (cnt_r < 32'(HIGH_CYC));
    end
  end

  assign wave = wave_r;

  a_tb_duty: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(wave_r) |-> (cnt_r == 32'(HIGH_CYC + 1)))
    else $error("time base high phase has wrong length");
endmodule
`default_nettype wire

// ==== host_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Clock
  input  wire logic clk_sys,
  // Serial link
  input  wire logic serial_out_level,
  output logic      bus_select,
  output logic      bus_shift_strobe,
  output logic      serial_in_line
);
  initial begin
    bus_select = 1'b0;
    bus_shift_strobe = 1'b0;
    serial_in_line = 1'b0;
  end

  // Four clocks low, four high: the 160 ns strobe period
  task automatic shift_bit(input logic b, output logic seen);
    bus_shift_strobe <= 1'b0;
    serial_in_line <= b;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    seen = serial_out_level;
    @(posedge clk_sys);
    bus_shift_strobe <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic frame(input logic [7:0] adr, input logic [38:0] w,
                       input int len, input logic idle,
                       output logic [22:0] rd);
    logic s;
    w[30:27] = 4'h0;
    bus_shift_strobe <= idle;
    repeat (4) @(posedge clk_sys);
    bus_select <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) shift_bit(adr[i], s);
    for (int i = 0; i < len; i++) begin
      shift_bit(w[i], s);
      rd = {rd[21:0], s};
    end
    bus_shift_strobe <= idle;
    repeat (4) @(posedge clk_sys);
    bus_select <= 1'b0;
    // Released line shows the inverse, never a stale value
    serial_in_line <= ~serial_in_line;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== tuner_pll_serial_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_serial_control_test;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pll_unlocked_in = 1'b0, count_signal_input = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic pready, pslverr, irq, bus_select, bus_shift_strobe, serial_in_line;
  logic serial_out_o, serial_out_oe_n, bidir_pin_one_o, bidir_pin_one_oe_n;
  logic bidir_pin_two_o, bidir_pin_two_oe_n, timebase_out_pin, err;
  logic charge_pump_out, charge_pump_force_low, input_sensitivity_sel;
  logic fm_local_osc_input, am_local_osc_input, ref_is_25khz;
  logic e1 = 1'b1, e2 = 1'b0, pd = 1'b1;
  logic [2:0] factory_test_bits;
  logic [16:0] effective_divisor;
  logic [3:0] ref_select;
  logic [22:0] rd;
  logic [38:0] w;
  int fail_count = 0, comparisons = 0, n;
  wire logic p1 = bidir_pin_one_oe_n ? e1 : bidir_pin_one_o;
  wire logic p2 = bidir_pin_two_oe_n ? e2 : bidir_pin_two_o;
  wire logic so = serial_out_oe_n ? 1'b1 : serial_out_o;

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) count_signal_input <= ~count_signal_input;

  tuner_pll_serial_control #(.TB_PERIOD_CYC(50), .TB_HIGH_CYC(20),
    .GATE_CYC(100)) u_dut (.clk_sys, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .bus_select,
    .bus_shift_strobe, .serial_in_line, .serial_out_o, .serial_out_oe_n,
    .bidir_pin_one_i(p1), .bidir_pin_one_o, .bidir_pin_one_oe_n,
    .bidir_pin_two_i(p2), .bidir_pin_two_o, .bidir_pin_two_oe_n,
    .pll_unlocked_in, .phase_pump_drive(pd), .count_signal_input,
    .timebase_out_pin, .charge_pump_out, .charge_pump_force_low,
    .input_sensitivity_sel, .factory_test_bits, .fm_local_osc_input,
    .am_local_osc_input, .effective_divisor, .ref_select, .ref_is_25khz);

  host_link_model u_host (.clk_sys, .serial_out_level(so), .bus_select,
    .bus_shift_strobe, .serial_in_line);

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (n == 40) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic send(input logic [38:0] x, input logic [7:0] a);
    u_host.frame(a, x, 39, x[0], rd);
    repeat (8) @(posedge clk_sys);
  endtask

  function automatic logic [16:0] exp_div(input logic [38:0] x);
    if (x[17]) return {x[15:0], 1'b0};
    if (x[16]) return {1'b0, x[15:0]};
    return {5'h00, x[15:4]};
  endfunction

  initial begin
    v = $urandom(30);
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, tuner_pll_pkg::OFF_CTRL_LO, 32'h0);
    chk("reset ctrl", v, 0);
    chk("reset test", factory_test_bits, 0);
    for (int i = 0; i < 6; i++) begin
      w = 39'({$urandom, $urandom});
      w[26] = (i != 5);
      w[17:16] = 2'(i % 3);
      pd <= w[38];
      if (i == 1) w[23:20] = tuner_pll_pkg::REF_25K;
      send(w, 8'hA5);
      apb(1'b0, tuner_pll_pkg::OFF_CTRL_LO, 32'h0);
      chk("ctrl", v, w[31:0] & 32'h87FF_FFFF);
      chk("div", effective_divisor, exp_div(w));
      chk("path", {fm_local_osc_input, am_local_osc_input},
          {w[17], ~w[17]});
      chk("ref", {ref_select, ref_is_25khz},
          {w[23:20], w[23:20] == 4'h2});
      chk("pump", {charge_pump_force_low, charge_pump_out,
          input_sensitivity_sel}, {w[25], ~w[25] & w[38], w[26]});
      chk("test", factory_test_bits, 0);
    end
    u_host.frame(8'hA5, ~w, 20, 1'b0, rd);
    apb(1'b0, tuner_pll_pkg::OFF_CTRL_LO, 32'h0);
    chk("short frame", v, w[31:0] & 32'h87FF_FFFF);
    apb(1'b1, tuner_pll_pkg::OFF_MASK, 32'h1);
    chk("irq on", irq, 1);
    apb(1'b0, tuner_pll_pkg::OFF_STATUS, 32'h0);
    chk("irq cleared", {v[0], irq}, 2'b10);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", err, 1);
    chk("unmapped data", v, 0);
    $display("test controls done");
    send(39'h04_0500_0000, 8'hA5);
    n = 0;
    repeat (50) begin
      @(posedge clk_sys);
      n += timebase_out_pin;
    end
    chk("wave high", n, 20);
    send(39'h06_0400_0000, 8'hA5);
    chk("tb data", timebase_out_pin, 1);
    n = $urandom;
    e1 <= n[0];
    e2 <= ~n[0];
    send(39'h06_0402_0000, 8'hA5);
    apb(1'b0, tuner_pll_pkg::OFF_COUNT, 32'h0);
    chk("held", v[19:0], 0);
    send(39'h06_0406_0000, 8'hA5);
    for (int k = 0; k < 40 && v[1] !== 1'b1; k++)
      apb(1'b0, tuner_pll_pkg::OFF_STATUS, 32'h0);
    chk("done", v[1], 1);
    u_host.frame(8'h5A, 39'h0, 23, 1'b0, rd);
    // Pin one is an output driving its data bit 0
    chk("pins lock", rd[22:20], {e2, 1'b0, 1'b1});
    chk("count", rd[19:0] > 48 && rd[19:0] < 52, 1);
    $display("test count done");
    pll_unlocked_in <= 1'b1;
    send(39'h40_8404_0000, 8'hA5);
    chk("unlock pin", serial_out_oe_n, 0);
    u_host.frame(8'h5A, 39'h0, 23, 1'b1, rd);
    chk("lock flag", rd[20], 0);
    $display("test unlock done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
